/* hw/dtc_map.vh */
/*
 * Register offsets, field positions, command codes and reset values of the
 * toggle and thermal control block.
 * Assumes a 32-bit AHB-Lite bus with word-aligned single transfers.
 */
`ifndef DTC_MAP_VH
`define DTC_MAP_VH

// Byte offsets of the registers.
`define DTC_OFS_CMD       8'h00
`define DTC_OFS_CTRL      8'h04
`define DTC_OFS_STATUS    8'h08
`define DTC_OFS_PWRUP     8'h0C

// Command word fields.
`define DTC_CMD_DATA_MSB  13
`define DTC_CMD_ADDR_LSB  16
`define DTC_CMD_ADDR_MSB  20
`define DTC_CMD_SEL_LO    21
`define DTC_CMD_SEL_HI    22

// Register-select codes and the control-register channel address.
`define DTC_SEL_SPECIAL   2'b00
`define DTC_SEL_B         2'b10
`define DTC_SEL_A         2'b11
`define DTC_CTRL_ADDR     5'h0C

// Control register fields.
`define DTC_CTRL_TOG_LSB  2
`define DTC_CTRL_TOG_MSB  5
`define DTC_CTRL_THERM    8
`define DTC_CTRL_RST      14'h0000

// Status register fields.
`define DTC_ST_LATCHED    0
`define DTC_ST_HOT        1

// Bit of the power-up register that requests a soft power-up.
`define DTC_PWRUP_BIT     0

// Idle images of the pin synchronisers: strobe pin high, no overheat.
`define DTC_LDN_IDLE      3'h7
`define DTC_HOT_IDLE      2'h0

// Reset value of every data register.
`define DTC_DATA_RST      14'h0000

`endif

/* hw/dtc_toggle_thermal.v */
/*
 * Toggle-mode output selection and thermal shutdown control of a
 * 32-channel DAC, with an AHB-Lite register slave.
 * Assumes the over-temperature comparator and the load strobe pin are
 * asynchronous, and that the bus is the only master of the registers.
 */
//
// Overview of operation
// [RQ1] Select 00, address 01100 writes control
// [RQ2] Control bits five to two enable toggle groups
// [RQ3] Each of 32 channels has A, B
// [RQ4] B writes ignored unless group toggles
// [RQ5] Host enables, loads A, B, then strobes
// [RQ6] First strobe shows A, then alternate
// [RQ7] Strobe rate alone sets square frequency
// [RQ8] After disable, next strobe shows A
// [RQ9] Protection active only with bit eight set
// [RQ10] Overheat powers down all output amplifiers
// [RQ11] Stays down until cool power-up or disable
// [RQ12] Lowest toggle bit covers channels zero-seven
// [RQ13] Shutdown latch held until power-up/disable
`timescale 1ns/1ps
`include "dtc_map.vh"

module dtc_toggle_thermal
(
    input  wire         CLK,
    input  wire         SYS_RST,
    input  wire         HSEL,
    input  wire [7:0]   HADDR,
    input  wire [1:0]   HTRANS,
    input  wire         HWRITE,
    input  wire [2:0]   HSIZE,
    input  wire [31:0]  HWDATA,
    input  wire         HREADY,
    output reg  [31:0]  HRDATA,
    output reg          HREADYOUT,
    output reg          HRESP,
    input  wire         OUTPUT_LOAD_STROBE_N,
    input  wire         OVER_TEMP,
    output reg  [447:0] DAC_CODE,
    output reg          AMP_PD
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    reg  [13:0] a_mem [0:31];      // A data register of each channel.
    reg  [13:0] b_mem [0:31];      // B data register of each channel.
    reg  [13:0] ctrl_q;            // Control register image.
    reg         latched_q;         // Thermal shutdown latch.
    reg  [3:0]  primed_q;          // Group has seen its first strobe.
    reg  [3:0]  src_b_q;           // Group currently shows its B data.
    reg         wr_pend_q;         // A write data phase is due.
    reg  [7:0]  wr_addr_q;         // Address captured for that write.
    reg  [2:0]  ldn_sync_q;        // Strobe synchroniser and edge history.
    reg  [1:0]  hot_sync_q;        // Over-temperature synchroniser.
    reg         pwrup_q;           // One-cycle soft power-up request.
    wire        hot;               // Synchronised over-temperature level.
    wire        strobe;            // One-cycle load strobe event.
    wire        therm_en;          // Protection enable bit.
    wire [3:0]  tog_en;            // Toggle enable per group of eight.
    wire        addr_ph;           // Valid address phase this cycle.
    wire [1:0]  cmd_sel;           // Register select of a command word.
    wire [4:0]  cmd_addr;          // Channel address of a command word.
    wire [13:0] cmd_data;          // Data field of a command word.
    integer     i;                 // Loop index for the data arrays.

    assign hot      = hot_sync_q[1];
    assign strobe   = ~ldn_sync_q[1] & ldn_sync_q[2];
    assign therm_en = ctrl_q[`DTC_CTRL_THERM];
    assign tog_en   = ctrl_q[`DTC_CTRL_TOG_MSB:`DTC_CTRL_TOG_LSB]; // RQ2
    assign addr_ph  = HSEL & HTRANS[1] & HREADY;
    assign cmd_sel  = {HWDATA[`DTC_CMD_SEL_HI], HWDATA[`DTC_CMD_SEL_LO]};
    assign cmd_addr = HWDATA[`DTC_CMD_ADDR_MSB:`DTC_CMD_ADDR_LSB];
    assign cmd_data = HWDATA[`DTC_CMD_DATA_MSB:0];

    // Toggle enable of the group that holds a channel; used by the B write
    // gate and by the per-channel output selection.
    function group_en;
        input [3:0] en;
        input [4:0] ch;
        begin
            group_en = en[ch[4:3]]; // RQ12
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers. The first stage is read only by the second.

    // The strobe edge is taken between stages two and three, never stage one.
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            ldn_sync_q <= `DTC_LDN_IDLE;
            hot_sync_q <= `DTC_HOT_IDLE;
        end
        else
        begin
            ldn_sync_q <= {ldn_sync_q[1:0], OUTPUT_LOAD_STROBE_N};
            hot_sync_q <= {hot_sync_q[0], OVER_TEMP};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: address phase capture and read data.

    // Reads are answered with zero wait states: the read word is registered
    // at the address phase edge so it stands for the whole data phase.
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            HRDATA    <= 32'h00000000;
            HREADYOUT <= 1'b0;
            HRESP     <= 1'b0;
        end
        else
        begin
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            wr_pend_q <= addr_ph & HWRITE;
            wr_addr_q <= HADDR;
            if (addr_ph && !HWRITE && HADDR == `DTC_OFS_CTRL)
            begin
                // Control register image in the low bits.
                HRDATA <= {18'h00000, ctrl_q};
            end
            else if (addr_ph && !HWRITE && HADDR == `DTC_OFS_STATUS)
            begin
                // Latch, live temperature flag and amplifier state.
                HRDATA <= {29'h00000000, AMP_PD, hot, latched_q};
            end
            else
            begin
                // Unmapped and write-only offsets read as zero.
                HRDATA <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command decode: control and data register writes.

    // The command word mimics the device's serial word: select bits, a
    // channel address and a 14-bit data field.
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            ctrl_q  <= `DTC_CTRL_RST;
            pwrup_q <= 1'b0;
            for (i = 0; i < 32; i = i + 1)
            begin
                a_mem[i] <= `DTC_DATA_RST; // RQ3
                b_mem[i] <= `DTC_DATA_RST;
            end
        end
        else
        begin
            pwrup_q <= wr_pend_q & (wr_addr_q == `DTC_OFS_PWRUP) & HWDATA[`DTC_PWRUP_BIT];
            if (wr_pend_q && wr_addr_q == `DTC_OFS_CMD)
            begin
                if (cmd_sel == `DTC_SEL_SPECIAL && cmd_addr == `DTC_CTRL_ADDR)
                begin
                    ctrl_q <= cmd_data; // RQ1
                end
                else if (cmd_sel == `DTC_SEL_A)
                begin
                    a_mem[cmd_addr] <= cmd_data; // RQ3
                end
                else if (cmd_sel == `DTC_SEL_B && group_en(tog_en, cmd_addr))
                begin
                    b_mem[cmd_addr] <= cmd_data; // RQ4
                end
            end
            else if (wr_pend_q && wr_addr_q == `DTC_OFS_CTRL)
            begin
                // Direct access to the same control register.
                ctrl_q <= HWDATA[13:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Toggle state per group of eight channels.

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : grp
            // A disabled group loses its priming at once, so a later
            // re-enable starts again from the A data.
            always @(posedge CLK)
            begin
                if (SYS_RST)
                begin
                    primed_q[g] <= 1'b0;
                    src_b_q[g]  <= 1'b0;
                end
                else if (!tog_en[g])
                begin
                    primed_q[g] <= 1'b0;
                    if (strobe)
                    begin
                        src_b_q[g] <= 1'b0; // RQ8
                    end
                end
                else if (strobe)
                begin
                    primed_q[g] <= 1'b1;
                    src_b_q[g]  <= primed_q[g] & ~src_b_q[g]; // RQ6
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Output codes, updated only on a load strobe.

    // No internal timer exists: each strobe makes exactly one update.
    genvar c;
    generate
        for (c = 0; c < 32; c = c + 1)
        begin : chn
            // Channel number as a five-bit constant for the group lookup.
            localparam [4:0] CH = c;

            always @(posedge CLK)
            begin
                if (SYS_RST)
                begin
                    DAC_CODE[c*14 +: 14] <= `DTC_DATA_RST;
                end
                else if (strobe)
                begin
                    // Next source mirrors the group state update above.
                    if (group_en(tog_en, CH) && primed_q[c/8] && !src_b_q[c/8])
                    begin
                        DAC_CODE[c*14 +: 14] <= b_mem[c]; // RQ6
                    end
                    else
                    begin
                        DAC_CODE[c*14 +: 14] <= a_mem[c]; // RQ8
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Thermal shutdown latch.

    // Setting wins over a power-up in the same cycle, so a cool-down request
    // while still hot never releases the amplifiers.
    always @(posedge CLK)
    begin
        if (SYS_RST)
        begin
            latched_q <= 1'b0;
            AMP_PD    <= 1'b0;
        end
        else
        begin
            if (therm_en && hot)
            begin
                latched_q <= 1'b1; // RQ10
            end
            else if (!therm_en || pwrup_q)
            begin
                latched_q <= 1'b0; // RQ11
            end
            AMP_PD <= (therm_en & hot) | (latched_q & therm_en & ~pwrup_q); // RQ9 RQ13
        end
    end

endmodule // dtc_toggle_thermal

/* testbench/dtc_monitor.sv */
/* Assertion checker of the toggle and thermal block.
   Sees only the top module ports; bound below the module. */
`timescale 1ns/1ps
module dtc_monitor (
    input logic         CLK,
    input logic         SYS_RST,
    input logic         HSEL,
    input logic         HWRITE,
    input logic         HREADY,
    input logic         HREADYOUT,
    input logic         HRESP,
    input logic         OUTPUT_LOAD_STROBE_N,
    input logic         OVER_TEMP,
    input logic         AMP_PD,
    input logic [1:0]   HTRANS,
    input logic [7:0]   HADDR,
    input logic [31:0]  HWDATA,
    input logic [31:0]  HRDATA,
    input logic [447:0] DAC_CODE
);
    logic       wa_q, ls_q, prot_q; // Write seen, old strobe level, protect bit.
    logic [7:0] ad_q;               // Address of the pending write.
    logic [2:0] pw_q, st_q;         // Ages of last power-up and last strobe.
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    ////////////////////////////////////////////////////////////
    // Shadows the protect bit, since the checker cannot read registers.
    always @(posedge CLK)
    begin
        wa_q <= HSEL && HTRANS[1] && HREADY && HWRITE;
        ad_q <= HADDR;
        ls_q <= OUTPUT_LOAD_STROBE_N;
        if (SYS_RST)
        begin
            {pw_q, st_q} <= 6'h3F;
            prot_q <= 1'b0;
        end
        else
        begin
            pw_q <= (wa_q && ad_q == 8'h0C && HWDATA[0]) ? 3'h0 : pw_q + {2'h0, pw_q != 3'h7};
            st_q <= (ls_q && !OUTPUT_LOAD_STROBE_N) ? 3'h0 : st_q + {2'h0, st_q != 3'h7};
            if (wa_q && (ad_q == 8'h04 || (ad_q == 8'h00 && HWDATA[22:16] == 7'h0C)))
                prot_q <= HWDATA[8];
        end
    end
    ////////////////////////////////////////////////////////////
    a_ready_after_reset: assert property (!SYS_RST |=> HREADYOUT)
        else $error("slave not ready");
    a_resp_okay: assert property (!HRESP)
        else $error("error response");
    a_rdata_idle: assert property (!$past(HSEL && HTRANS[1] && HREADY && !HWRITE) |-> HRDATA == 32'h0)
        else $error("stray read data");
    a_code_on_strobe: assert property ($changed(DAC_CODE) |-> st_q inside {[1:5]})
        else $error("code moved without strobe");
    a_pd_needs_prot: assert property ($rose(AMP_PD) |-> prot_q)
        else $error("shutdown while unprotected");
    a_prot_off_clear: assert property (!prot_q && !$past(prot_q) && !$past(prot_q, 2) |-> !AMP_PD)
        else $error("shutdown kept while unprotected");
    a_hot_shutdown: assert property ((prot_q && OVER_TEMP) [*4] |=> AMP_PD)
        else $error("no shutdown when hot");
    a_latch_holds: assert property ($fell(AMP_PD) |-> !prot_q || pw_q < 3'h6)
        else $error("shutdown dropped by itself");
endmodule // dtc_monitor

bind dtc_toggle_thermal dtc_monitor dtc_monitor_i (.CLK, .SYS_RST, .HSEL, .HWRITE, .HREADY, .HREADYOUT,
    .HRESP, .OUTPUT_LOAD_STROBE_N, .OVER_TEMP, .AMP_PD, .HTRANS, .HADDR, .HWDATA, .HRDATA, .DAC_CODE);

/* testbench/dtc_host_model.sv */
/* Host-side model of the load strobe pin.
   Assumes fire is a one-cycle request from the bench. */
`timescale 1ns/1ps
module dtc_host_model (
    input  logic clk,
    input  logic fire,
    output logic load_n
);
    int n = 0; // Cycles left in the current pulse.
    // Low three cycles, then high at least three, so the pin sync sees each pulse once.
    always @(posedge clk)
    begin
        n      <= fire ? 6 : (n > 0 ? n - 1 : 0);
        load_n <= !(n > 3);
    end
endmodule // dtc_host_model

/* testbench/dtc_toggle_thermal_tb.sv */
/* Self-checking bench of the toggle and thermal block.
   Drives the bus and temperature pin; the host model makes the strobe. */
`timescale 1ns/1ps
module dtc_toggle_thermal_tb;
    logic CLK = 0, SYS_RST = 1, HSEL = 0, HWRITE = 0, OVER_TEMP = 0, fire = 0, rd_ph = 0;
    logic HREADYOUT, HRESP, AMP_PD, load_n;
    logic [1:0] HTRANS = 0;
    logic [7:0] HADDR = 0;
    logic [31:0] HWDATA = 0, HRDATA, exp_q [$];
    logic [447:0] DAC_CODE, dac_q [$];
    logic [13:0] a [32], b [32], ctrl = 0; // Model of data registers and control.
    logic ph [4];                          // Next strobe of a group shows B.
    int fails = 0, samples_checked = 0;
    always #4 CLK = ~CLK;
    dtc_toggle_thermal dtc_toggle_thermal_i (.CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2),
        .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .OUTPUT_LOAD_STROBE_N(load_n),
        .OVER_TEMP, .DAC_CODE, .AMP_PD);
    dtc_host_model dtc_host_model_i (.clk(CLK), .fire, .load_n);
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (!ok)
        begin
            fails++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic stop_test;
        $display("checked %0d, failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // One single AHB transfer; holds each phase until ready is sampled high.
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd, ex);
        @(posedge CLK) {HSEL, HTRANS, HADDR, HWRITE} <= {1'b1, 2'h2, ad, wr};
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        {HSEL, HTRANS, HWDATA, rd_ph} <= {3'h0, wd, !wr};
        if (!wr)
            exp_q.push_back(ex);
        do @(posedge CLK); while (HREADYOUT !== 1'b1);
        rd_ph <= 1'b0;
    endtask
    // Writes, then lets the pin and latch logic settle before the next look.
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        bus(1'b1, ad, d, 32'h0);
        repeat (4) @(posedge CLK);
        if (ad == 8'h04)
            ctrl = d[13:0];
        foreach (ph[g]) if (!ctrl[g + 2]) ph[g] = 1'b0;
    endtask
    task automatic cmd(input logic [1:0] s, input logic [4:0] c, input logic [13:0] d);
        if (s == 2'b00 && c == 5'h0C)
            ctrl = d;
        wr(8'h00, {9'h0, s, c, 2'h0, d});
        if (s == 2'b11)
            a[c] = d;
        if (s == 2'b10 && ctrl[c[4:3] + 2])
            b[c] = d;
    endtask
    task automatic heat(input logic v);
        OVER_TEMP <= v;
        repeat (6) @(posedge CLK);
    endtask
    // Notes the code every channel should show, then pulses the strobe.
    task automatic strobe;
        logic [447:0] e;
        for (int c = 0; c < 32; c++) e[c * 14 +: 14] = (ctrl[c / 8 + 2] && ph[c / 8]) ? b[c] : a[c];
        foreach (ph[g]) ph[g] = ctrl[g + 2] && !ph[g];
        dac_q.push_back(e);
        fire <= 1'b1;
        @(posedge CLK) fire <= 1'b0;
        repeat (10) @(posedge CLK);
    endtask
    ////////////////////////////////////////////////////////////
    // Watches the outputs and compares each result with the oldest note.
    always @(posedge CLK)
        if (rd_ph)
            chk(HRDATA === exp_q.pop_front(), "read data");
    always @(negedge load_n)
    begin
        repeat (6) @(posedge CLK);
        chk(DAC_CODE === dac_q.pop_front(), "output code");
    end
    // The tests need about 640 cycles; the limit leaves a wide margin.
    initial
    begin
        #20us;
        fails++;
        stop_test;
    end
    initial
    begin
        foreach (a[c]) {a[c], b[c]} = 28'h0;
        foreach (ph[g]) ph[g] = 1'b0;
        void'($urandom(32'h4B50));
        repeat (4) @(posedge CLK);
        SYS_RST <= 1'b0;
        @(posedge CLK);
        bus(1'b0, 8'h04, 32'h0, 32'h0);
        bus(1'b0, 8'h10, 32'h0, 32'h0);
        cmd(2'b00, 5'h0C, 14'h0014);
        foreach (a[c]) cmd(2'b11, c[4:0], 14'($urandom));
        foreach (b[c]) cmd(2'b10, c[4:0], 14'($urandom));
        repeat (4) strobe;
        wr(8'h04, 32'h3C);
        bus(1'b0, 8'h04, 32'h0, 32'h3C);
        repeat (2) strobe;
        wr(8'h04, 32'h0);
        strobe;
        heat(1'b1);
        bus(1'b0, 8'h08, 32'h0, 32'h2);
        cmd(2'b00, 5'h0C, 14'h0100);
        bus(1'b0, 8'h08, 32'h0, 32'h7);
        heat(1'b0);
        bus(1'b0, 8'h08, 32'h0, 32'h5);
        heat(1'b1);
        wr(8'h0C, 32'h1);
        bus(1'b0, 8'h08, 32'h0, 32'h7);
        heat(1'b0);
        wr(8'h0C, 32'h1);
        bus(1'b0, 8'h08, 32'h0, 32'h0);
        heat(1'b1);
        wr(8'h04, 32'h0);
        bus(1'b0, 8'h08, 32'h0, 32'h2);
        stop_test;
    end
endmodule // dtc_toggle_thermal_tb
